// ### hdl/bneir_top.sv
/*
  bneir_top: node interface registers of the bus adapter: error interrupt
  control, interrupt target node mask, window start/end, scratch registers.
  assumes: register port and system bus signals are on clk_i; node id comes
  from pins; self-test logic pulses selftest_done_i with its result.
*/
// How it works
// - interrupt command only while allow bit set
// - done bit set when command starts
// - issued bit held until identify; stop clears
// - force bit raises interrupt regardless of errors
// - adapter error with allow sets force bit
// - level field picks levels, bit16 is level0
// - identify answer returns vector field
// - target mask has one bit per node
// - answer only on mask bit and level match
// - self-test sets own node bit in mask
// - interrupt before mask written sets abort bit
// - start field from node id at self-test
// - end field is start plus window size
// - scratch zero holds self-test error number on fail, cleared on pass
// - scratch one to three cleared at self-test
// - adapter error with allow starts interrupt
`timescale 1ns/1ps
`default_nettype none
module bneir_top
  import bneir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // node id pins and self-test results
  input wire logic [NODE_W-1:0] node_id_i,
  input wire logic selftest_done_i,
  input wire logic selftest_pass_i,
  input wire logic [ERRNUM_W-1:0] selftest_errnum_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_nack_o,
  // error sources
  input wire logic bus_err_i,
  input wire logic adapter_err_i,
  input wire logic adapter_err_irq_allow_i,
  input wire logic host_irq_i,
  // interrupt command
  output logic intr_req_o,
  output logic [LEVEL_W-1:0] intr_level_o,
  output logic [NODES-1:0] intr_dest_o,
  input wire logic intr_start_i,
  input wire logic stop_i,
  // identify cycle
  input wire logic identify_cycle_i,
  input wire logic [NODE_W-1:0] ident_master_i,
  input wire logic [LEVEL_W-1:0] ident_level_i,
  output logic ident_hit_o,
  output logic [VECTOR_W-1:0] ident_vector_o,
  // window decode
  input wire logic addr_valid_i,
  input wire logic [31:0] addr_i,
  output logic win_hit_o
);

  // register select codes
  localparam int SEL_NONE = 0;
  localparam int SEL_ERR = 1;
  localparam int SEL_MASK = 2;
  localparam int SEL_START = 3;
  localparam int SEL_END = 4;
  localparam int SEL_HOST = 5;
  localparam int SEL_SCR = 6;

  // decode an offset into a register select
  function automatic int reg_sel(input logic [7:0] a);
    int s;
    s = SEL_NONE;
    unique case (a)
      OFF_ERR_CTRL: s = SEL_ERR;
      OFF_TARGET_MASK: s = SEL_MASK;
      OFF_WIN_START: s = SEL_START;
      OFF_WIN_END: s = SEL_END;
      OFF_HOST_CTRL: s = SEL_HOST;
      OFF_SCRATCH0, OFF_SCRATCH1, OFF_SCRATCH2, OFF_SCRATCH3: s = SEL_SCR;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  logic [NODE_W-1:0] node_id;
  logic wr_err;
  logic wr_mask;
  logic wr_start;
  logic wr_end;
  logic wr_host;
  logic wr_scr;
  logic [1:0] scr_idx;

  // error control fields
  logic allow_q;
  logic done_q;
  logic abort_q;
  logic force_q;
  logic [LEVEL_W-1:0] level_q;
  logic [VECTOR_W-1:0] vector_q;
  logic berr_pend_q;
  bneir_state_t state_q;
  bneir_state_t state_d;
  logic issued;
  logic raise;
  logic mask_set_q;
  logic [NODES-1:0] mask_q;
  logic [WIN_W-1:0] start_q;
  logic [WIN_W-1:0] end_q;
  logic [31:0] host_q;
  logic [15:0] scr_q [4];
  logic ident_ok;
  logic ident_hit_q;
  logic [VECTOR_W-1:0] ident_vec_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic nack_q;
  logic [31:0] rd_mux;
  logic win_hit_q;
  logic [WIN_W-1:0] own_start;

  // node id pins pass through a three-flop synchroniser
  bneir_sync3 #(
    .W(NODE_W)
  ) u_node_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(node_id_i),
    .val_o(node_id)
  );

  // write strobes per register
  assign wr_err = reg_wr_i && (reg_sel(reg_addr_i) == SEL_ERR);
  assign wr_mask = reg_wr_i && (reg_sel(reg_addr_i) == SEL_MASK);
  assign wr_start = reg_wr_i && (reg_sel(reg_addr_i) == SEL_START);
  assign wr_end = reg_wr_i && (reg_sel(reg_addr_i) == SEL_END);
  assign wr_host = reg_wr_i && (reg_sel(reg_addr_i) == SEL_HOST);
  assign wr_scr = reg_wr_i && (reg_sel(reg_addr_i) == SEL_SCR);
  assign scr_idx = reg_addr_i[3:2];

  // interrupt wanted: forced, or a latched bus error
  assign raise = force_q || berr_pend_q;
  assign issued = (state_q == BNEIR_WAIT_ID);

  // identify match: mask bit of requesting node and level overlap
  assign ident_ok = identify_cycle_i && issued && mask_q[ident_master_i]
                    && ((ident_level_i & level_q) != '0);

  // software-writable control fields
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      allow_q <= 1'b0;
      level_q <= '0;
      vector_q <= '0;
    end else if (wr_err) begin
      allow_q <= reg_wdata_i[ALLOW_BIT];
      level_q <= reg_wdata_i[LEVEL_LSB +: LEVEL_W];
      vector_q <= reg_wdata_i[VECTOR_W-1:0];
    end
  end

  // force bit: adapter error set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      force_q <= 1'b0;
    end else if (adapter_err_i && adapter_err_irq_allow_i) begin
      force_q <= 1'b1;
    end else if (wr_err) begin
      force_q <= reg_wdata_i[FORCE_BIT];
    end
  end

  // bus error pending until answered or aborted
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      berr_pend_q <= 1'b0;
    end else if (bus_err_i) begin
      berr_pend_q <= 1'b1;
    end else if (ident_ok || (state_q == BNEIR_IDLE && allow_q && !mask_set_q)) begin
      berr_pend_q <= 1'b0;
    end
  end

  // error interrupt sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BNEIR_IDLE: begin
        if (raise && allow_q && mask_set_q) begin
          state_d = BNEIR_REQ;
        end
      end
      BNEIR_REQ: begin
        if (stop_i || !allow_q) begin
          state_d = BNEIR_IDLE;
        end else if (intr_start_i) begin
          state_d = BNEIR_WAIT_ID;
        end
      end
      BNEIR_WAIT_ID: begin
        if (stop_i || ident_ok) begin
          state_d = BNEIR_IDLE;
        end
      end
      default: state_d = BNEIR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= BNEIR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // done flag: set on command start, write one clears, set wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
    end else if (state_q == BNEIR_REQ && intr_start_i && !stop_i) begin
      done_q <= 1'b1;
    end else if (wr_err && reg_wdata_i[DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // abort flag: interrupt raised before software named a target
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      abort_q <= 1'b0;
    end else if (state_q == BNEIR_IDLE && raise && allow_q && !mask_set_q) begin
      abort_q <= 1'b1;
    end else if (wr_err && reg_wdata_i[ABORT_BIT]) begin
      abort_q <= 1'b0;
    end
  end

  // target node mask, own bit set by self-test
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_q <= TARGET_MASK_RST;
      mask_set_q <= 1'b0;
    end else if (wr_mask) begin
      mask_q <= reg_wdata_i[NODES-1:0];
      mask_set_q <= 1'b1;
    end else if (selftest_done_i) begin
      mask_q <= NODES'(1) << node_id;
      mask_set_q <= 1'b0;
    end
  end

  // base of own window from node id
  assign own_start = WIN_BASE_FIELD + WIN_W'(WIN_STEP_FIELD * node_id);

  // window start and end, loaded by self-test
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      start_q <= WIN_RST;
      end_q <= WIN_RST;
    end else if (selftest_done_i) begin
      start_q <= own_start;
      end_q <= own_start + WIN_STEP_FIELD;
    end else begin
      if (wr_start) begin
        start_q <= reg_wdata_i[WIN_LSB +: WIN_W];
      end
      if (wr_end) begin
        end_q <= reg_wdata_i[WIN_LSB +: WIN_W];
      end
    end
  end

  // host-side interrupt control, abort bit on early host interrupt
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      host_q <= '0;
    end else begin
      if (wr_host) begin
        host_q <= reg_wdata_i & ~(32'h1 << ABORT_BIT);
      end
      if (host_irq_i && !mask_set_q) begin
        host_q[ABORT_BIT] <= 1'b1;
      end else if (wr_host && reg_wdata_i[ABORT_BIT]) begin
        host_q[ABORT_BIT] <= 1'b0;
      end
    end
  end

  // scratch registers, loaded by self-test
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_scr
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          scr_q[g] <= SCRATCH_RST;
        end else if (selftest_done_i) begin
          if (g == 0 && !selftest_pass_i) begin
            scr_q[g] <= 16'(selftest_errnum_i) << ERRNUM_LSB;
          end else begin
            scr_q[g] <= SCRATCH_RST;
          end
        end else if (wr_scr && scr_idx == 2'(g)) begin
          scr_q[g] <= reg_wdata_i[15:0];
        end
      end
    end
  endgenerate

  // identify answer, one-cycle pulse with vector
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ident_hit_q <= 1'b0;
      ident_vec_q <= '0;
    end else begin
      ident_hit_q <= ident_ok;
      if (ident_ok) begin
        ident_vec_q <= vector_q;
      end
    end
  end

  // read multiplexer
  always_comb begin
    rd_mux = '0;
    unique case (reg_sel(reg_addr_i))
      SEL_ERR: begin
        rd_mux[ABORT_BIT] = abort_q;
        rd_mux[ALLOW_BIT] = allow_q;
        rd_mux[DONE_BIT] = done_q;
        rd_mux[ISSUED_BIT] = issued;
        rd_mux[FORCE_BIT] = force_q;
        rd_mux[LEVEL_LSB +: LEVEL_W] = level_q;
        rd_mux[VECTOR_W-1:0] = vector_q;
      end
      SEL_MASK: rd_mux[NODES-1:0] = mask_q;
      SEL_START: rd_mux[WIN_LSB +: WIN_W] = start_q;
      SEL_END: rd_mux[WIN_LSB +: WIN_W] = end_q;
      SEL_HOST: rd_mux = host_q;
      SEL_SCR: rd_mux[15:0] = scr_q[scr_idx];
      default: rd_mux = '0;
    endcase
  end

  // register answer one cycle after the access
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      ack_q <= (reg_rd_i || reg_wr_i) && (reg_sel(reg_addr_i) != SEL_NONE);
      nack_q <= (reg_rd_i || reg_wr_i) && (reg_sel(reg_addr_i) == SEL_NONE);
      rdata_q <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  // window compare, registered
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      win_hit_q <= 1'b0;
    end else begin
      win_hit_q <= addr_valid_i && (addr_i[31:30] == 2'b00)
                   && (addr_i[29:16] >= start_q) && (addr_i[29:16] < end_q);
    end
  end

  // outputs
  assign reg_rdata_o = rdata_q;
  assign reg_ack_o = ack_q;
  assign reg_nack_o = nack_q;
  assign intr_req_o = (state_q == BNEIR_REQ) && allow_q;
  assign intr_level_o = level_q;
  assign intr_dest_o = mask_q;
  assign ident_hit_o = ident_hit_q;
  assign ident_vector_o = ident_vec_q;
  assign win_hit_o = win_hit_q;

endmodule
`default_nettype wire

// ### include/bneir_pkg.sv
/*
  bneir_pkg: offsets, field positions, reset values and constants for the
  bus node error interrupt register block.
  assumes: a 32-bit register port with byte offsets, at most 16 bus nodes.
*/
`default_nettype none
package bneir_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_ERR_CTRL = 8'h0c;
  localparam logic [7:0] OFF_TARGET_MASK = 8'h10;
  localparam logic [7:0] OFF_WIN_START = 8'h24;
  localparam logic [7:0] OFF_WIN_END = 8'h28;
  localparam logic [7:0] OFF_HOST_CTRL = 8'h38;
  localparam logic [7:0] OFF_SCRATCH0 = 8'h40;
  localparam logic [7:0] OFF_SCRATCH1 = 8'h44;
  localparam logic [7:0] OFF_SCRATCH2 = 8'h48;
  localparam logic [7:0] OFF_SCRATCH3 = 8'h4c;

  // error interrupt control field positions
  localparam int ABORT_BIT = 25;
  localparam int ALLOW_BIT = 24;
  localparam int DONE_BIT = 23;
  localparam int ISSUED_BIT = 21;
  localparam int FORCE_BIT = 20;
  localparam int LEVEL_LSB = 16;
  localparam int LEVEL_W = 4;
  localparam int VECTOR_W = 8;

  // window address field: bits 29-16
  localparam int WIN_LSB = 16;
  localparam int WIN_W = 14;
  localparam logic [WIN_W-1:0] WIN_BASE_FIELD = 14'h2000;
  localparam logic [WIN_W-1:0] WIN_STEP_FIELD = 14'h0008;

  // scratch register 0 error number field: bits 15-10
  localparam int ERRNUM_LSB = 10;
  localparam int ERRNUM_W = 6;

  // node numbering
  localparam int NODE_W = 4;
  localparam int NODES = 16;

  // reset values
  localparam logic [NODES-1:0] TARGET_MASK_RST = 16'h0000;
  localparam logic [WIN_W-1:0] WIN_RST = 14'h0000;
  localparam logic [15:0] SCRATCH_RST = 16'h0000;

  // error interrupt channel sequence
  typedef enum logic [1:0] {
    BNEIR_IDLE = 2'b00,
    BNEIR_REQ = 2'b01,
    BNEIR_WAIT_ID = 2'b11
  } bneir_state_t;

endpackage
`default_nettype wire

// ### hdl/bneir_sync3.sv
/*
  bneir_sync3: three-flop synchroniser for a bundle of pin inputs.
  assumes: the bundle changes slowly; a value is taken once stages two
  and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module bneir_sync3 #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] val_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] val_q;

  // shift chain, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept the value once the two later stages agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      val_q <= '0;
    end else if (s2_q == s3_q) begin
      val_q <= s3_q;
    end
  end

  assign val_o = val_q;

endmodule
`default_nettype wire

// ### bench/bneir_node_model.sv
/*
  bneir_node_model: far-side bus node that starts interrupt commands.
  assumes: request is a level, start goes back as a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module bneir_node_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic slow_i,
  output logic start_o
);
  logic [2:0] cnt_q;
  // quiet until the first edge
  initial begin
    start_o = 1'b0;
    cnt_q = 3'h0;
  end
  // start after zero or four request cycles
  always @(negedge clk_i) begin
    if (!rst_n_i || !req_i) begin
      cnt_q <= 3'h0;
      start_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      start_o <= cnt_q == (slow_i ? 3'h4 : 3'h0);
    end
  end
endmodule
`default_nettype wire

// ### bench/bneir_monitor.sv
/*
  bneir_monitor: port checks on the node register block.
  assumes: bound to bneir_top; one clock, sync active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bneir_monitor
  import bneir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic selftest_done_i,
  input wire logic reg_wr_i,
  input wire logic intr_req_o,
  input wire logic [LEVEL_W-1:0] intr_level_o,
  input wire logic [NODES-1:0] intr_dest_o,
  input wire logic intr_start_i,
  input wire logic stop_i,
  input wire logic identify_cycle_i,
  input wire logic [NODE_W-1:0] ident_master_i,
  input wire logic [LEVEL_W-1:0] ident_level_i,
  input wire logic ident_hit_o,
  input wire logic [VECTOR_W-1:0] ident_vector_o,
  input wire logic addr_valid_i,
  input wire logic [31:0] addr_i,
  input wire logic win_hit_o
);
  logic mask_q, lvl_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // identify qualifiers one cycle back
  always_ff @(posedge clk_i) begin
    mask_q <= intr_dest_o[ident_master_i];
    lvl_q <= |(ident_level_i & intr_level_o);
  end
  // command taken by the bus
  sequence s_taken;
    intr_req_o && intr_start_i;
  endsequence
  // request with nothing to end it
  sequence s_open;
    intr_req_o && !intr_start_i && !stop_i && !reg_wr_i && !selftest_done_i;
  endsequence
  a_req_holds: assert property (s_open |=> intr_req_o)
    else $error("request dropped early");
  a_req_drops: assert property (s_taken |=> !intr_req_o)
    else $error("request stays after start");
  a_stop_ends: assert property (stop_i |=> !intr_req_o)
    else $error("request after stop");
  a_hit_cause: assert property (ident_hit_o |-> $past(identify_cycle_i) && mask_q && lvl_q)
    else $error("identify answered without match");
  a_hit_single: assert property (ident_hit_o |=> !ident_hit_o)
    else $error("identify answer too long");
  a_vec_hold: assert property (!ident_hit_o |-> $stable(ident_vector_o))
    else $error("vector changed without answer");
  a_win_idle: assert property (!addr_valid_i |=> !win_hit_o)
    else $error("window hit without access");
  a_win_high: assert property (addr_valid_i && addr_i[31:30] != 2'b00 |=> !win_hit_o)
    else $error("window hit above field");
endmodule
`default_nettype wire

// ### bench/tb_bneir_top.sv
/*
  tb_bneir_top: self-checking bench for the node register block.
  assumes: package, design, node model and monitor compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_bneir_top;
  import bneir_pkg::*;
  logic clk_i, rst_n_i, done, pass, wr, rd, berr, aerr, aok, hirq, stp, idc, av;
  logic start, slow, ack, nack, req, hit, wh;
  logic [3:0] nid, im, il, lvl, lvo;
  logic [5:0] en;
  logic [7:0] ad, vec, vo;
  logic [15:0] msk, dst;
  logic [31:0] wd, addr, rdo, rdq, st, ed, base;
  int errors, total_checks, cyc, seed;
  bneir_top bneir_top_inst (
    .clk_i, .rst_n_i, .node_id_i(nid), .selftest_done_i(done), .selftest_pass_i(pass),
    .selftest_errnum_i(en), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_rdata_o(rdo), .reg_ack_o(ack), .reg_nack_o(nack), .bus_err_i(berr), .adapter_err_i(aerr),
    .adapter_err_irq_allow_i(aok), .host_irq_i(hirq), .intr_req_o(req), .intr_level_o(lvo),
    .intr_dest_o(dst), .intr_start_i(start), .stop_i(stp), .identify_cycle_i(idc),
    .ident_master_i(im), .ident_level_i(il), .ident_hit_o(hit), .ident_vector_o(vo),
    .addr_valid_i(av), .addr_i(addr), .win_hit_o(wh)
  );
  bneir_node_model bneir_node_model_inst (.clk_i, .rst_n_i, .req_i(req), .slow_i(slow), .start_o(start));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic nx(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one register access, answer one cycle later
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ok);
    nx(1);
    wr = w;
    rd = !w;
    ad = a;
    wd = d;
    nx(1);
    wr = 1'b0;
    rd = 1'b0;
    rdq = rdo;
    chk(32'({ack, nack}), 32'({ok, !ok}));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 1'b1);
    chk(rdq, e);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 1'b1);
  endtask
  // one-cycle pulse on an event input
  task automatic pl(input int s);
    nx(1);
    case (s)
      0: berr = 1'b1;
      1: aerr = 1'b1;
      2: hirq = 1'b1;
      default: stp = 1'b1;
    endcase
    nx(1);
    {berr, aerr, hirq, stp} = 4'h0;
  endtask
  task automatic ident(input logic [3:0] m, input logic [3:0] l, input logic h);
    nx(1);
    idc = 1'b1;
    im = m;
    il = l;
    nx(1);
    idc = 1'b0;
    chk(32'(hit), 32'(h));
    if (h) chk(32'(vo), 32'(vec));
  endtask
  function automatic logic [31:0] wstart(input logic [3:0] n);
    return {2'b00, WIN_BASE_FIELD + WIN_STEP_FIELD * 14'(n), 16'h0000};
  endfunction
  function automatic logic wexp(input logic [31:0] a);
    return a[31:30] == 2'b00 && a[29:16] >= st[29:16] && a[29:16] < ed[29:16];
  endfunction
  task automatic win(input logic [31:0] a);
    nx(1);
    av = 1'b1;
    addr = a;
    nx(1);
    av = 1'b0;
    chk(32'(wh), 32'(wexp(a)));
  endtask
  // self-test run on a node, then window probes
  task automatic selftest(input logic [3:0] node, input logic ok);
    for (int k = 4; k < 16; k += 4) wrr(OFF_SCRATCH0 + 8'(k), $urandom);
    nid = node;
    en = 6'($urandom);
    pass = ok;
    nx(6);
    done = 1'b1;
    nx(1);
    done = 1'b0;
    st = wstart(node);
    ed = st + (32'(WIN_STEP_FIELD) << WIN_LSB);
    rchk(OFF_TARGET_MASK, 32'h1 << node);
    rchk(OFF_WIN_START, st);
    rchk(OFF_WIN_END, ed);
    rchk(OFF_SCRATCH0, ok ? 32'h0 : 32'(en) << ERRNUM_LSB);
    for (int k = 4; k < 16; k += 4) rchk(OFF_SCRATCH0 + 8'(k), 32'h0);
    win(st - 32'h1);
    win(st);
    win(ed - 32'h1);
    win(ed);
    win(st | 32'h4000_0000);
    win($urandom);
  endtask
  // wait for the command to be taken, checking what it carries
  task automatic await_start();
    for (int k = 0; k < 12 && start !== 1'b1; k++) begin
      nx(1);
      if (req === 1'b1) begin
        chk(32'(lvo), 32'(lvl));
        chk(32'(dst), 32'(msk));
      end
    end
    chk(32'(start), 32'h1);
    nx(1);
    chk(32'(req), 32'h0);
  endtask
  // main sequence
  initial begin
    seed = $urandom(32'hf58d);
    {rst_n_i, done, pass, wr, rd, berr, aerr, aok, hirq, stp, idc, av, slow} = '0;
    {nid, im, il, lvl, en, ad, vec, wd, addr, msk} = '0;
    nx(10);
    rst_n_i = 1'b1;
    rchk(OFF_TARGET_MASK, 32'h0);
    rchk(OFF_WIN_START, 32'h0);
    rchk(OFF_SCRATCH0, 32'h0);
    acc(1'b1, 8'h14, 32'hffff_ffff, 1'b0);
    $display("test reset done");
    selftest(4'($urandom), 1'b0);
    selftest(4'hf, 1'b0);
    selftest(4'($urandom), 1'b1);
    $display("test self-test done");
    wrr(OFF_ERR_CTRL, 32'h0100_0000);
    wrr(OFF_HOST_CTRL, 32'h0);
    pl(0);
    pl(2);
    nx(3);
    chk(32'(req), 32'h0);
    rchk(OFF_ERR_CTRL, 32'h0300_0000);
    rchk(OFF_HOST_CTRL, 32'h0200_0000);
    wrr(OFF_HOST_CTRL, 32'h0200_0000);
    wrr(OFF_ERR_CTRL, 32'h0200_0000);
    rchk(OFF_ERR_CTRL, 32'h0);
    $display("test abort done");
    msk = (16'($urandom) | 16'h0004) & 16'hffdf;
    vec = 8'($urandom);
    wrr(OFF_TARGET_MASK, 32'(msk));
    chk(32'(dst), 32'(msk));
    wrr(OFF_ERR_CTRL, 32'h0010_0000);
    nx(4);
    chk(32'(req), 32'h0);
    // every level, bus error or force cause, prompt or slow node
    for (int i = 0; i < 4; i++) begin
      lvl = 4'h1 << i;
      slow = i[1];
      base = 32'h0100_0000 | 32'(lvl) << LEVEL_LSB | 32'(vec);
      wrr(OFF_ERR_CTRL, i[0] ? base | 32'h0010_0000 : base);
      if (!i[0]) pl(0);
      await_start();
      wrr(OFF_ERR_CTRL, base);
      rchk(OFF_ERR_CTRL, base | 32'h00a0_0000);
      if (i == 3) begin
        pl(3);
      end else begin
        ident(4'h5, lvl, 1'b0);
        ident(4'h2, {lvl[2:0], lvl[3]}, 1'b0);
        ident(4'h2, lvl, 1'b1);
      end
      rchk(OFF_ERR_CTRL, base | 32'h0080_0000);
      wrr(OFF_ERR_CTRL, base | 32'h0080_0000);
    end
    $display("test interrupt done");
    pl(1);
    rchk(OFF_ERR_CTRL, base);
    aok = 1'b1;
    pl(1);
    rchk(OFF_ERR_CTRL, base | 32'h0010_0000);
    await_start();
    wrr(OFF_ERR_CTRL, base);
    ident(4'h2, lvl, 1'b1);
    ident(4'h2, lvl, 1'b0);
    $display("test adapter error done");
    close_out();
  end
endmodule
bind bneir_top bneir_monitor bneir_monitor_inst (
  .clk_i, .rst_n_i, .selftest_done_i, .reg_wr_i, .intr_req_o, .intr_level_o, .intr_dest_o,
  .intr_start_i, .stop_i, .identify_cycle_i, .ident_master_i, .ident_level_i, .ident_hit_o,
  .ident_vector_o, .addr_valid_i, .addr_i, .win_hit_o
);
`default_nettype wire
